// >>> src/psq_pkg.sv
// Shared constants for the programmable sequencer core
package psq_pkg;
  // ****************************************************************
  // Array and memory geometry
  // ****************************************************************
  localparam int PSQ_COND_INPUTS = 8;
  localparam int PSQ_SELECT_BITS = 6;
  localparam int PSQ_ARRAY_INPUTS = 14;
  localparam int PSQ_TERMS_PER_SUM = 8;
  localparam int PSQ_TERM_COUNT = 16;
  localparam int PSQ_FUSE_WIDTH = 28;
  localparam int PSQ_WORD_COUNT = 128;
  localparam int PSQ_WORD_WIDTH = 21;
  localparam int PSQ_ADDR_WIDTH = 7;
  localparam int PSQ_LOW_ADDR_WIDTH = 5;
  localparam int PSQ_USER_WIDTH = 8;

  // ****************************************************************
  // Memory word field positions
  // ****************************************************************
  localparam int PSQ_USER_LSB = 0;
  localparam int PSQ_LOW_ADDR_LSB = 8;
  localparam int PSQ_SELECT_LSB = 13;
  localparam int PSQ_FORCE_LOW_BIT = 19;
  localparam int PSQ_FORCE_HIGH_BIT = 20;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [20:0] PSQ_OUT_RESET = 21'h1f_ffff;
  localparam logic [20:0] PSQ_SHADOW_RESET = 21'h00_0000;
  localparam logic [27:0] PSQ_FUSE_RESET = 28'hfff_ffff;

  // ****************************************************************
  // Programming port map
  // ****************************************************************
  localparam int PSQ_BUS_ADDR_WIDTH = 8;
  localparam int PSQ_BUS_DATA_WIDTH = 32;
  localparam logic [7:0] PSQ_MEM_BASE = 8'h00;
  localparam logic [7:0] PSQ_TERM_BASE = 8'h80;
  localparam logic [7:0] PSQ_TERM_LAST = 8'h8f;
  localparam logic [7:0] PSQ_OUT_STATUS = 8'h90;
  localparam logic [7:0] PSQ_SHADOW_STATUS = 8'h91;
  localparam logic [7:0] PSQ_ADDR_STATUS = 8'h92;
  localparam logic [31:0] PSQ_READ_ZERO = 32'h0000_0000;
endpackage : psq_pkg

// >>> src/psq_cond_array.sv
// Condition AND-OR array with two active-high sums
`timescale 1ns/1ps
module psq_cond_array
  import psq_pkg::*;
#(
  parameter int TERMS_PER_SUM = PSQ_TERMS_PER_SUM
) (
  // Array inputs and fuse map
  input wire logic [PSQ_ARRAY_INPUTS-1:0] array_in,
  input wire logic [2*TERMS_PER_SUM*PSQ_FUSE_WIDTH-1:0] fuse_in,
  // Sums
  output logic array_sum_low_out,
  output logic array_sum_high_out
);
  // ****************************************************************
  // Literals and product terms
  // ****************************************************************
  logic [PSQ_FUSE_WIDTH-1:0] literal;
  logic [2*TERMS_PER_SUM-1:0] term;

  genvar gi;
  generate
    if (TERMS_PER_SUM != PSQ_TERMS_PER_SUM) begin : g_bad
      $error("psq_cond_array supports exactly eight terms per sum");
    end
    // Even fuse selects the true literal, odd fuse the complement
    for (gi = 0; gi < PSQ_ARRAY_INPUTS; gi++) begin : g_lit
      assign literal[2*gi] = array_in[gi];
      assign literal[2*gi+1] = ~array_in[gi];
    end
    // Intact fuse keeps the literal in the AND; all intact gives zero
    for (gi = 0; gi < 2*TERMS_PER_SUM; gi++) begin : g_term
      assign term[gi] =
        &(literal | ~fuse_in[gi*PSQ_FUSE_WIDTH +: PSQ_FUSE_WIDTH]);
    end
  endgenerate

  // ****************************************************************
  // Sums: terms 0-7 to the low sum, 8-15 to the high sum
  // ****************************************************************
  assign array_sum_low_out = |term[TERMS_PER_SUM-1:0];
  assign array_sum_high_out = |term[2*TERMS_PER_SUM-1:TERMS_PER_SUM];
endmodule : psq_cond_array

// >>> src/psq_core.sv
// Programmable sequencer core: array, state memory, output and shadow registers
//
// Contract
// - Fourteen dual-rail inputs, two eight-term sums
// - Eight external conditions, six select bits fed back
// - State memory of 128 words, 21 bits
// - Word: eight outputs, thirteen feedback bits
// - Force bits set quadrant bits when not branching
// - Non-branching select bits enable no term
// - Branch reaches four quadrants, same low address
// - Word passes through synchronous output register
// - Shadow shifts on own clock, undisturbing; here the synchronised shadow clock edge enables a shift on clock_in
// - Shadow loads output register; output captured back
// - Shadow input mux: parallel or shift
// - Registered outputs update on rising clock
// - Init sets all ones, next state 127
// - Each sum xored with matching force bit
`timescale 1ns/1ps
module psq_core
  import psq_pkg::*;
#(
  parameter int COND_WIDTH = PSQ_COND_INPUTS,
  parameter int USER_WIDTH = PSQ_USER_WIDTH
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // External condition pins
  input wire logic [COND_WIDTH-1:0] condition_in,
  // Shadow register pins
  input wire logic shadow_clock_in,
  input wire logic shadow_data_in,
  input wire logic shadow_capture_in,
  input wire logic shadow_load_in,
  output logic shadow_data_out,
  // Programming port
  input wire logic [PSQ_BUS_ADDR_WIDTH-1:0] prog_addr_in,
  input wire logic [PSQ_BUS_DATA_WIDTH-1:0] prog_wdata_in,
  input wire logic prog_write_in,
  input wire logic prog_read_in,
  output logic [PSQ_BUS_DATA_WIDTH-1:0] prog_rdata_out,
  // Sequencer outputs
  output logic [USER_WIDTH-1:0] user_out,
  output logic [PSQ_ADDR_WIDTH-1:0] state_addr_out
);
  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  generate
    if (COND_WIDTH != PSQ_COND_INPUTS) begin : g_bad_cond
      $error("psq_core needs exactly eight condition inputs");
    end
    if (USER_WIDTH != PSQ_USER_WIDTH) begin : g_bad_user
      $error("psq_core needs exactly eight user outputs");
    end
  endgenerate

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Conditions and shadow pins come from outside this clock domain
  logic [COND_WIDTH-1:0] cond_meta;
  logic [COND_WIDTH-1:0] cond_sync;
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic shadow_clock_last;
  logic shadow_load_last;

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      cond_meta <= '0;
      cond_sync <= '0;
    end else begin
      cond_meta <= condition_in;
      cond_sync <= cond_meta;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
    end else begin
      pin_meta <= {shadow_load_in, shadow_capture_in, shadow_data_in, shadow_clock_in};
      pin_sync <= pin_meta;
    end
  end

  // Edge history is taken from the second stage only
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      shadow_clock_last <= 1'b0;
      shadow_load_last <= 1'b0;
    end else begin
      shadow_clock_last <= pin_sync[0];
      shadow_load_last <= pin_sync[3];
    end
  end

  logic shadow_step;
  logic shadow_load;
  // Shadow clock is a pin, so its rising edge becomes a one-cycle enable
  assign shadow_step = pin_sync[0] & ~shadow_clock_last;
  assign shadow_load = pin_sync[3] & ~shadow_load_last;

  // ****************************************************************
  // State memory and fuse map
  // ****************************************************************
  logic [PSQ_WORD_WIDTH-1:0] state_mem [PSQ_WORD_COUNT];
  logic [2*PSQ_TERMS_PER_SUM*PSQ_FUSE_WIDTH-1:0] fuse_map;
  logic mem_hit;
  logic term_hit;
  logic [3:0] term_index;

  assign mem_hit = prog_addr_in < PSQ_TERM_BASE;
  assign term_hit = (prog_addr_in >= PSQ_TERM_BASE) && (prog_addr_in <= PSQ_TERM_LAST);
  assign term_index = prog_addr_in[3:0];

  // Memory is fuse content: no reset, software fills it before use
  always_ff @(posedge clock_in) begin
    if (prog_write_in && mem_hit) begin
      state_mem[prog_addr_in[PSQ_ADDR_WIDTH-1:0]] <= prog_wdata_in[PSQ_WORD_WIDTH-1:0];
    end
  end

  // All fuses intact after reset, so every product term reads zero
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      fuse_map <= {2*PSQ_TERMS_PER_SUM{PSQ_FUSE_RESET}};
    end else if (prog_write_in && term_hit) begin
      fuse_map[term_index*PSQ_FUSE_WIDTH +: PSQ_FUSE_WIDTH] <=
        prog_wdata_in[PSQ_FUSE_WIDTH-1:0];
    end
  end

  // ****************************************************************
  // Output register fields
  // ****************************************************************
  logic [PSQ_WORD_WIDTH-1:0] out_reg;
  logic [PSQ_WORD_WIDTH-1:0] shadow_reg;
  logic [PSQ_LOW_ADDR_WIDTH-1:0] low_addr;
  logic [PSQ_SELECT_BITS-1:0] select_bits;
  logic xor_force_low;
  logic xor_force_high;

  // Word split: outputs, low address, select bits, two force bits
  assign low_addr = out_reg[PSQ_LOW_ADDR_LSB +: PSQ_LOW_ADDR_WIDTH];
  assign select_bits = out_reg[PSQ_SELECT_LSB +: PSQ_SELECT_BITS];
  assign xor_force_low = out_reg[PSQ_FORCE_LOW_BIT];
  assign xor_force_high = out_reg[PSQ_FORCE_HIGH_BIT];

  // ****************************************************************
  // Condition array and next address
  // ****************************************************************
  logic [PSQ_ARRAY_INPUTS-1:0] array_inputs;
  logic array_sum_low;
  logic array_sum_high;
  logic quadrant_bit_low;
  logic quadrant_bit_high;
  logic [PSQ_ADDR_WIDTH-1:0] next_addr;

  // Synced pins plus registered select feedback form the fourteen inputs
  assign array_inputs = {select_bits, cond_sync};

  // Select patterns that enable no term give zero sums
  psq_cond_array #(
    .TERMS_PER_SUM(PSQ_TERMS_PER_SUM)
  ) u_cond_array (
    .array_in(array_inputs),
    .fuse_in(fuse_map),
    .array_sum_low_out(array_sum_low),
    .array_sum_high_out(array_sum_high)
  );

  // Zero sums pass the force bits through; set sums toggle the quadrant
  assign quadrant_bit_high = array_sum_high ^ xor_force_high;
  assign quadrant_bit_low = array_sum_low ^ xor_force_low;
  assign next_addr = {quadrant_bit_high, quadrant_bit_low, low_addr};

  // ****************************************************************
  // Output register
  // ****************************************************************
  // A shadow load overrides the normal state step for that cycle
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      out_reg <= PSQ_OUT_RESET;
    end else if (shadow_load) begin
      out_reg <= shadow_reg;
    end else begin
      out_reg <= state_mem[next_addr];
    end
  end

  // Current address kept for readback and for the state pins
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      state_addr_out <= '1;
    end else if (shadow_load) begin
      state_addr_out <= '1;
    end else begin
      state_addr_out <= next_addr;
    end
  end

  assign user_out = out_reg[PSQ_USER_LSB +: PSQ_USER_WIDTH];

  // ****************************************************************
  // Shadow register
  // ****************************************************************
  // Only touches the output register on an explicit load pulse
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      shadow_reg <= PSQ_SHADOW_RESET;
    end else if (shadow_step) begin
      if (pin_sync[2]) begin
        shadow_reg <= out_reg;
      end else begin
        shadow_reg <= {pin_sync[1], shadow_reg[PSQ_WORD_WIDTH-1:1]};
      end
    end
  end

  assign shadow_data_out = shadow_reg[0];

  // ****************************************************************
  // Programming port readback
  // ****************************************************************
  logic [PSQ_BUS_DATA_WIDTH-1:0] next_rdata;

  always_comb begin
    next_rdata = PSQ_READ_ZERO;
    if (mem_hit) begin
      next_rdata = {11'h000, state_mem[prog_addr_in[PSQ_ADDR_WIDTH-1:0]]};
    end else if (term_hit) begin
      next_rdata = {4'h0, fuse_map[term_index*PSQ_FUSE_WIDTH +: PSQ_FUSE_WIDTH]};
    end else if (prog_addr_in == PSQ_OUT_STATUS) begin
      next_rdata = {11'h000, out_reg};
    end else if (prog_addr_in == PSQ_SHADOW_STATUS) begin
      next_rdata = {11'h000, shadow_reg};
    end else if (prog_addr_in == PSQ_ADDR_STATUS) begin
      next_rdata = {25'h000_0000, state_addr_out};
    end
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      prog_rdata_out <= PSQ_READ_ZERO;
    end else if (prog_read_in) begin
      prog_rdata_out <= next_rdata;
    end else begin
      prog_rdata_out <= PSQ_READ_ZERO;
    end
  end
endmodule : psq_core

// >>> sim/psq_far_end.sv
// Far-side model: controlled system driving the condition pins
`timescale 1ns/1ps
module psq_far_end (
  // Clock
  input wire logic clock_in,
  // Requested quadrant and pace
  input wire logic [1:0] want_in,
  input wire logic slow_in,
  // Condition pins
  output logic [7:0] condition_out
);
  logic [1:0] prompt;
  logic [1:0] mid;
  logic [1:0] late;
  logic [5:0] spin = 6'h15;
  // Unused pins churn every cycle so a stale level never passes for real data
  always_ff @(posedge clock_in) begin
    prompt <= want_in;
    mid <= prompt;
    late <= mid;
    spin <= spin + 6'h01;
  end
  assign condition_out = {spin, slow_in ? late : prompt};
endmodule : psq_far_end

// >>> sim/psq_core_props.sv
// Checker for the programmable sequencer core ports
`timescale 1ns/1ps
module psq_core_props
  import psq_pkg::*;
#(
  parameter int USER_WIDTH = PSQ_USER_WIDTH
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // Shadow pins
  input wire logic shadow_clock_in,
  input wire logic shadow_load_in,
  input wire logic shadow_data_out,
  // Programming port
  input wire logic [PSQ_BUS_ADDR_WIDTH-1:0] prog_addr_in,
  input wire logic prog_read_in,
  input wire logic [PSQ_BUS_DATA_WIDTH-1:0] prog_rdata_out,
  // Sequencer outputs
  input wire logic [USER_WIDTH-1:0] user_out,
  input wire logic [PSQ_ADDR_WIDTH-1:0] state_addr_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  logic rd_out;
  assign rd_out = prog_read_in && prog_addr_in == PSQ_OUT_STATUS && !shadow_load_in;
  a_init_all_high: assert property ($rose(rst_b_in) |-> user_out == '1 &&
    state_addr_out == '1 ##1 state_addr_out == '1) else $error("init state wrong");
  a_user_from_reg: assert property (rd_out |=>
    prog_rdata_out[USER_WIDTH-1:0] == $past(user_out)) else $error("user out not register");
  a_low_addr_next: assert property (rd_out |=>
    state_addr_out[4:0] == prog_rdata_out[12:8]) else $error("low address not fed back");
  a_force_quadrant: assert property (rd_out |=> prog_rdata_out[18:13] != 6'h3f ||
    state_addr_out[6:5] == prog_rdata_out[20:19]) else $error("force bits ignored");
  a_state_status: assert property (prog_read_in && prog_addr_in == PSQ_ADDR_STATUS |=>
    prog_rdata_out[6:0] == $past(state_addr_out)) else $error("state status wrong");
  a_rdata_drops: assert property (!prog_read_in |=> prog_rdata_out == PSQ_READ_ZERO)
    else $error("read data lingers");
  a_unmapped_zero: assert property (prog_read_in && prog_addr_in > PSQ_ADDR_STATUS |=>
    prog_rdata_out == PSQ_READ_ZERO) else $error("unmapped read not zero");
  a_shadow_quiet: assert property ((!shadow_clock_in) [*6] |-> $stable(shadow_data_out))
    else $error("shadow moved without shift clock");
  a_load_to_top: assert property ($rose(shadow_load_in) |-> ##[2:5] state_addr_out == '1)
    else $error("shadow load not seen");
  a_shadow_status: assert property (prog_read_in && prog_addr_in == PSQ_SHADOW_STATUS |=>
    prog_rdata_out[0] == $past(shadow_data_out)) else $error("shadow status wrong");
  c_status_read: cover property (rd_out);
  c_shadow_load: cover property ($rose(shadow_load_in));
  c_quadrant_top: cover property (state_addr_out == 7'h63);
endmodule : psq_core_props

bind psq_core psq_core_props #(.USER_WIDTH(USER_WIDTH)) psq_core_props_inst (
  .clock_in(clock_in), .rst_b_in(rst_b_in), .shadow_clock_in(shadow_clock_in),
  .shadow_load_in(shadow_load_in), .shadow_data_out(shadow_data_out),
  .prog_addr_in(prog_addr_in), .prog_read_in(prog_read_in), .prog_rdata_out(prog_rdata_out),
  .user_out(user_out), .state_addr_out(state_addr_out));

// >>> sim/tb_psq_core.sv
// Testbench for the programmable sequencer core
`timescale 1ns/1ps
module tb_psq_core import psq_pkg::*;;
  logic clk, rst_b, sclk, sdata, scap, sload, pw, pr, sdo, slow;
  logic [7:0] paddr, user, cond;
  logic [31:0] pwdata, rdata, v;
  logic [6:0] saddr;
  logic [1:0] want;
  logic [20:0] bits;
  int err_count = 0;
  int tests_run = 0;
  psq_core #(.COND_WIDTH(8), .USER_WIDTH(8)) psq_core_inst (.clock_in(clk), .rst_b_in(rst_b),
    .condition_in(cond), .shadow_clock_in(sclk), .shadow_data_in(sdata),
    .shadow_capture_in(scap), .shadow_load_in(sload), .shadow_data_out(sdo),
    .prog_addr_in(paddr), .prog_wdata_in(pwdata), .prog_write_in(pw), .prog_read_in(pr),
    .prog_rdata_out(rdata), .user_out(user), .state_addr_out(saddr));
  psq_far_end psq_far_end_inst (.clock_in(clk), .want_in(want), .slow_in(slow),
    .condition_out(cond));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    pw <= 1'b1;
    paddr <= a;
    pwdata <= d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    pw <= 1'b0;
    pr <= 1'b1;
    paddr <= a;
    @(posedge clk);
    pr <= 1'b0;
    #1;
    d = rdata;
  endtask : rd
  // Bounded wait; running out ends the run as a failure
  task automatic wait_for(input bit on_user, input logic [7:0] val);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while ((on_user ? user : {1'b0, saddr}) !== val && n < 60);
    check("wait target", {24'h00_0000, on_user ? user : {1'b0, saddr}}, {24'h00_0000, val});
    if (err_count > 0) conclude();
  endtask : wait_for
  // One shadow step: pin held high three cycles so the synchroniser sees it
  task automatic sstep(input logic d, input logic c);
    @(posedge clk);
    sclk <= 1'b1;
    sdata <= d;
    scap <= c;
    repeat (3) @(posedge clk);
    sclk <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask : sstep
  initial begin
    {rst_b, sclk, sdata, scap, sload, pw, pr, slow} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    want = 2'b00;
    // Words: [20] force high, [19] force low, [18:13] select, [12:8] low, [7:0] user
    wr(8'h7f, 32'h0017_e55a);
    wr(8'h45, 32'h0000_0333);
    for (int q = 0; q < 4; q++) wr(8'(q * 32 + 3), 32'h0017_e5a0 + 32'(q));
    // Strobe drops right after the last write so no write repeats
    @(posedge clk);
    pw <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check("reset user", {24'h00_0000, user}, 32'h0000_00ff);
    check("reset state", {25'h000_0000, saddr}, 32'h0000_007f);
    @(posedge clk);
    rst_b <= 1'b1;
    // Terms need select bit 0 low, so the all-ones select pattern disables both
    wr(8'h80, 32'h0002_0001);
    wr(8'h88, 32'h0002_0004);
    rd(PSQ_SHADOW_STATUS, v);
    check("shadow reset", v, 32'h0000_0000);
    rd(8'ha0, v);
    check("unmapped read", v, 32'h0000_0000);
    $display("test reset and program done");
    for (int q = 0; q < 4; q++) begin
      @(posedge clk);
      want <= 2'(q);
      slow <= q[0];
      repeat (12) @(posedge clk);
      wait_for(1'b0, 8'h45);
      check("branch user", {24'h00_0000, user}, 32'h0000_0033);
      @(posedge clk);
      #1;
      check("quadrant state", {25'h000_0000, saddr}, 32'(q * 32 + 3));
      check("quadrant user", {24'h00_0000, user}, 32'h0000_00a0 + 32'(q));
      rd(PSQ_OUT_STATUS, v);
      check("branch word", v, 32'h0000_0333);
      @(posedge clk);
      rd(PSQ_OUT_STATUS, v);
      check("target word", v, 32'h0017_e5a0 + 32'(q));
      rd(PSQ_ADDR_STATUS, v);
      check("state status", v, 32'(q * 32 + 3));
    end
    $display("test branching done");
    bits = 21'h17_e5c3;
    for (int i = 0; i < 21; i++) sstep(bits[i], 1'b0);
    rd(PSQ_SHADOW_STATUS, v);
    check("shifted vector", v, 32'h0017_e5c3);
    @(posedge clk);
    sload <= 1'b1;
    wait_for(1'b1, 8'hc3);
    check("loaded state", {25'h000_0000, saddr}, 32'h0000_007f);
    @(posedge clk);
    sload <= 1'b0;
    #1;
    check("after load", {25'h000_0000, saddr}, 32'h0000_0045);
    sstep(1'b0, 1'b1);
    rd(PSQ_SHADOW_STATUS, v);
    // Capture step lands while the branch target word stands in the register
    check("captured", v, 32'h0017_e5a3);
    for (int i = 0; i < 21; i++) begin
      bits[i] = sdo;
      sstep(1'b0, 1'b0);
    end
    check("shifted out", {11'h000, bits}, 32'h0017_e5a3);
    $display("test shadow done");
    conclude();
  end
endmodule : tb_psq_core
